// >>> backlight_brightness_control.sv
// Purpose: brightness register, pwm duty product, sloper, sink enables
// Assumes: byte register port is the decoded output of the serial host
//          interface; pwm pin is asynchronous
// Notes:   sink current leaves as a code in nA
//
// How it works
// - active needs master, a sink, nonzero brightness
// - zero brightness or master off disables
// - code splits three low, eight high bits
// - code takes effect on high-register write
// - pwm timeout with input held low shuts down
// - combined mode: zero code or duty shuts down
// - sink two enable drives both sinks
// - pwm enabled: code times duty, then mapped
// - register mode ignores the pwm pin
// - exponential curve, 50uA times 1.003040572 power
// - linear curve, 37.8055uA plus 12.1945uA per code
// - one bit picks exponential or linear
// - slope time 0 to 8000ms, fixed
// - period measured rising edge to rising edge
// - polarity bit inverts pwm input
// - sample rate bit picks 1 or 4 MHz
// - input held high past timeout means full
`timescale 1ns/100ps
`default_nettype none
module backlight_brightness_control #(
  parameter int timeout_slow_samples =
    backlight_pkg::TIMEOUT_SLOW_MS * (backlight_pkg::SAMPLE_SLOW_HZ / 1000),
  parameter int timeout_fast_samples =
    backlight_pkg::TIMEOUT_FAST_MS * (backlight_pkg::SAMPLE_FAST_HZ / 1000),
  parameter int slope_tick_per_ms =
    backlight_pkg::CYCLES_PER_MS / backlight_pkg::SLOPE_STEPS
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_rvalid_out,
  // pwm pin
  input  wire logic        pwm_in,
  // sinks
  output logic             sink_one_output_out,
  output logic             sink_two_output_out,
  output logic [24:0]      sink_current_na_out,
  output logic             backlight_active_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]  curve_polarity_config;
  logic [7:0]  duty_sampling_config;
  logic [7:0]  brightness_low_bits;
  logic [7:0]  brightness_high_bits;
  logic [7:0]  duty_input_control;
  logic [7:0]  backlight_enable_control;
  logic [10:0] brightness_code;
  backlight_pkg::cfg_t cfg;

  logic        pwm_meta;
  logic        pwm_sync;
  logic [7:0]  sample_cnt;
  logic        sample_en;
  logic [15:0] timeout_samples;
  logic [11:0] duty;
  logic        pwm_timed_out;
  logic [22:0] product;
  logic [10:0] effective_code;
  logic        active;
  logic [10:0] target;

  backlight_pkg::slope_state_t slope_state;
  logic [18:0] level_fx;
  logic [10:0] slope_inc;
  logic        slope_up;
  logic [8:0]  steps_left;
  logic [31:0] tick_cnt;
  logic [31:0] tick_period;
  logic [10:0] last_target;

  // slope times in ms, index is slope_time_select
  function automatic logic [13:0] slope_ms(input logic [3:0] sel);
    case (sel)
      4'h0:    slope_ms = 14'd0;
      4'h1:    slope_ms = 14'd1;
      4'h2:    slope_ms = 14'd2;
      4'h3:    slope_ms = 14'd5;
      4'h4:    slope_ms = 14'd10;
      4'h5:    slope_ms = 14'd20;
      4'h6:    slope_ms = 14'd50;
      4'h7:    slope_ms = 14'd100;
      4'h8:    slope_ms = 14'd250;
      4'h9:    slope_ms = 14'd500;
      4'ha:    slope_ms = 14'd800;
      4'hb:    slope_ms = 14'd1000;
      4'hc:    slope_ms = 14'd2000;
      4'hd:    slope_ms = 14'd4000;
      4'he:    slope_ms = 14'd6000;
      default: slope_ms = 14'd8000;
    endcase
  endfunction

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      curve_polarity_config    <= backlight_pkg::REG_RESET;
      duty_sampling_config     <= backlight_pkg::REG_RESET;
      brightness_low_bits      <= backlight_pkg::REG_RESET;
      brightness_high_bits     <= backlight_pkg::REG_RESET;
      duty_input_control       <= backlight_pkg::REG_RESET;
      backlight_enable_control <= backlight_pkg::REG_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        backlight_pkg::ADDR_CURVE_POL: curve_polarity_config <= reg_wdata_in;
        backlight_pkg::ADDR_DUTY_SAMP: duty_sampling_config  <= reg_wdata_in;
        backlight_pkg::ADDR_BRT_LOW:   brightness_low_bits   <= reg_wdata_in;
        backlight_pkg::ADDR_BRT_HIGH:  brightness_high_bits  <= reg_wdata_in;
        backlight_pkg::ADDR_DUTY_CTL:  duty_input_control    <= reg_wdata_in;
        backlight_pkg::ADDR_BL_ENABLE:
          backlight_enable_control <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // low bits are staged; the code only moves on a high write
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      brightness_code <= 11'h000;
    else if (reg_wr_in && reg_addr_in == backlight_pkg::ADDR_BRT_HIGH)
      brightness_code <= {reg_wdata_in,
                          brightness_low_bits[backlight_pkg::LOW_BITS-1:0]};
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          backlight_pkg::ADDR_CURVE_POL:
            reg_rdata_out <= curve_polarity_config;
          backlight_pkg::ADDR_DUTY_SAMP: reg_rdata_out <= duty_sampling_config;
          backlight_pkg::ADDR_BRT_LOW:   reg_rdata_out <= brightness_low_bits;
          backlight_pkg::ADDR_BRT_HIGH:  reg_rdata_out <= brightness_high_bits;
          backlight_pkg::ADDR_DUTY_CTL:  reg_rdata_out <= duty_input_control;
          backlight_pkg::ADDR_BL_ENABLE:
            reg_rdata_out <= backlight_enable_control;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  always_comb
  begin
    cfg.curve_select =
      curve_polarity_config[backlight_pkg::BIT_CURVE];
    cfg.invert_polarity =
      curve_polarity_config[backlight_pkg::BIT_POLARITY];
    cfg.duty_sample_rate_select =
      duty_sampling_config[backlight_pkg::BIT_RATE];
    cfg.slope_time_select =
      duty_sampling_config[backlight_pkg::SLOPE_LSB +: 4];
    cfg.pwm_enable =
      duty_input_control[backlight_pkg::BIT_PWM_EN];
    cfg.backlight_master_enable =
      backlight_enable_control[backlight_pkg::BIT_MASTER];
    cfg.sink_one_enable =
      backlight_enable_control[backlight_pkg::BIT_SINK_ONE];
    cfg.sink_two_enable =
      backlight_enable_control[backlight_pkg::BIT_SINK_TWO];
  end

  // ****************************************************************
  // pwm pin sampling
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pwm_meta <= 1'b0;
      pwm_sync <= 1'b0;
    end
    else
    begin
      pwm_meta <= pwm_in;
      pwm_sync <= pwm_meta;
    end
  end

  // one pulse per pwm sample at 1 or 4 MHz
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      sample_cnt <= 8'h00;
    else if (sample_en)
      sample_cnt <= 8'h00;
    else
      sample_cnt <= sample_cnt + 8'h01;
  end

  assign sample_en = cfg.duty_sample_rate_select
    ? (sample_cnt == 8'(backlight_pkg::DIV_FAST - 1))
    : (sample_cnt == 8'(backlight_pkg::DIV_SLOW - 1));

  assign timeout_samples = cfg.duty_sample_rate_select
    ? 16'(timeout_fast_samples)
    : 16'(timeout_slow_samples);

  duty_detector detector (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .sample_en_in  (sample_en),
    .level_in      (pwm_sync ^ cfg.invert_polarity),
    .timeout_in    (timeout_samples),
    .duty_out      (duty),
    .timed_out_out (pwm_timed_out)
  );

  // ****************************************************************
  // effective code and enable
  // ****************************************************************
  always_comb
  begin
    product = {1'b0, brightness_code} * {11'h000, duty};
    // duty tops out at 2048, so the product never passes the code
    effective_code = cfg.pwm_enable ? product[21:11]
                                    : brightness_code;
    active = cfg.backlight_master_enable
           && (cfg.sink_one_enable || cfg.sink_two_enable)
           && effective_code != 11'h000;
    target = active ? effective_code : 11'h000;
  end

  // sinks switch with the enable, current follows the sloper
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sink_one_output_out  <= 1'b0;
      sink_two_output_out  <= 1'b0;
      backlight_active_out <= 1'b0;
    end
    else
    begin
      backlight_active_out <= active;
      sink_one_output_out  <= active;
      sink_two_output_out  <= active && cfg.sink_two_enable;
    end
  end

  // ****************************************************************
  // sloper: fixed 256 steps, whatever the distance; slope time 0 jumps at once
  // ****************************************************************
  assign tick_period = 32'(slope_ms(cfg.slope_time_select))
                     * 32'(slope_tick_per_ms);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      slope_state <= backlight_pkg::SLOPE_IDLE;
      level_fx    <= 19'h00000;
      slope_inc   <= 11'h000;
      slope_up    <= 1'b0;
      steps_left  <= 9'h000;
      tick_cnt    <= 32'h00000000;
      last_target <= 11'h000;
    end
    else
    begin
      last_target <= target;
      case (slope_state)
        backlight_pkg::SLOPE_IDLE:
        begin
          if (target != level_fx[18:8])
          begin
            if (tick_period == 32'h00000000)
              level_fx <= {target, 8'h00};
            else
            begin
              slope_up    <= target > level_fx[18:8];
              slope_inc   <= (target > level_fx[18:8])
                           ? target - level_fx[18:8]
                           : level_fx[18:8] - target;
              steps_left  <= 9'(backlight_pkg::SLOPE_STEPS);
              tick_cnt    <= 32'h00000000;
              slope_state <= backlight_pkg::SLOPE_RUN;
            end
          end
        end
        backlight_pkg::SLOPE_RUN:
        begin
          // a new target restarts the ramp from where it stands
          if (target != last_target)
            slope_state <= backlight_pkg::SLOPE_IDLE;
          else if (tick_cnt + 32'h00000001 >= tick_period)
          begin
            tick_cnt   <= 32'h00000000;
            steps_left <= steps_left - 9'h001;
            if (steps_left == 9'h001)
            begin
              level_fx    <= {target, 8'h00};
              slope_state <= backlight_pkg::SLOPE_IDLE;
            end
            else if (slope_up)
              level_fx <= level_fx + {8'h00, slope_inc};
            else
              level_fx <= level_fx - {8'h00, slope_inc};
          end
          else
            tick_cnt <= tick_cnt + 32'h00000001;
        end
        default: slope_state <= backlight_pkg::SLOPE_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // mapping
  // ****************************************************************
  current_mapper mapper (
    .clk_in          (clk_in),
    .srst_in         (srst_in),
    .curve_select_in (cfg.curve_select),
    .level_in        (level_fx[18:8]),
    .current_na_out  (sink_current_na_out)
  );

endmodule
`default_nettype wire

// >>> backlight_pkg.sv
// Purpose: shared constants and types for the backlight brightness path
// Assumes: 200 MHz system clock, byte-wide register port
// Notes:   offsets are register addresses on the byte register port
package backlight_pkg;

  // ****************************************************************
  // clocking and timing
  // ****************************************************************
  localparam int CLK_HZ          = 200_000_000;
  localparam int SAMPLE_SLOW_HZ  = 1_000_000;
  localparam int SAMPLE_FAST_HZ  = 4_000_000;
  localparam int DIV_SLOW        = CLK_HZ / SAMPLE_SLOW_HZ;
  localparam int DIV_FAST        = CLK_HZ / SAMPLE_FAST_HZ;
  localparam int TIMEOUT_SLOW_MS = 25;
  localparam int TIMEOUT_FAST_MS = 3;
  localparam int SLOPE_STEPS     = 256;
  localparam int CYCLES_PER_MS   = CLK_HZ / 1000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CURVE_POL = 8'h02;
  localparam logic [7:0] ADDR_DUTY_SAMP = 8'h03;
  localparam logic [7:0] ADDR_BRT_LOW   = 8'h04;
  localparam logic [7:0] ADDR_BRT_HIGH  = 8'h05;
  localparam logic [7:0] ADDR_DUTY_CTL  = 8'h09;
  localparam logic [7:0] ADDR_BL_ENABLE = 8'h0a;
  localparam logic [7:0] REG_RESET      = 8'h00;

  localparam int BIT_CURVE    = 4;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_RATE     = 2;
  localparam int SLOPE_LSB    = 3;
  localparam int BIT_PWM_EN   = 6;
  localparam int BIT_MASTER   = 0;
  localparam int BIT_SINK_ONE = 4;
  localparam int BIT_SINK_TWO = 3;
  localparam int LOW_BITS     = 3;

  // ****************************************************************
  // widths and types
  // ****************************************************************
  localparam int CODE_W = 11;
  localparam int DUTY_W = 12;
  localparam int CUR_W  = 25;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 12'h800;

  typedef struct packed {
    logic       curve_select;
    logic       invert_polarity;
    logic       duty_sample_rate_select;
    logic [3:0] slope_time_select;
    logic       pwm_enable;
    logic       backlight_master_enable;
    logic       sink_one_enable;
    logic       sink_two_enable;
  } cfg_t;

  typedef enum logic [1:0] {SLOPE_IDLE, SLOPE_RUN} slope_state_t;

endpackage

// >>> duty_detector.sv
// Purpose: measures pwm duty between rising edges, with timeout
// Assumes: level input already synchronised, one sample per sample_en
// Notes:   duty 2048 means 100 percent
`timescale 1ns/100ps
`default_nettype none
module duty_detector (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // samples
  input  wire logic        sample_en_in,
  input  wire logic        level_in,
  input  wire logic [15:0] timeout_in,
  // result
  output logic [11:0]      duty_out,
  output logic             timed_out_out
);
  logic        prev;
  logic        seen;
  logic [15:0] period_cnt;
  logic [15:0] high_cnt;
  logic [16:0] rem;
  logic [15:0] div_period;
  logic [11:0] quot;
  logic [3:0]  iter;
  logic        rise;
  logic [16:0] rem_sh;

  assign rise   = level_in & ~prev;
  assign rem_sh = {rem[15:0], 1'b0};

  // ****************************************************************
  // period and high time counting
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      prev       <= 1'b0;
      seen       <= 1'b0;
      period_cnt <= 16'h0000;
      high_cnt   <= 16'h0000;
      timed_out_out <= 1'b1;
    end
    else if (sample_en_in)
    begin
      prev <= level_in;
      if (rise)
      begin
        seen       <= 1'b1;
        period_cnt <= 16'h0001;
        high_cnt   <= 16'h0001;
        timed_out_out <= 1'b0;
      end
      else
      begin
        if (period_cnt != 16'hffff)
          period_cnt <= period_cnt + 16'h0001;
        if (level_in && high_cnt != 16'hffff)
          high_cnt <= high_cnt + 16'h0001;
        if (period_cnt >= timeout_in)
          timed_out_out <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // serial divide: high * 2048 / period, 11 steps
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rem        <= 17'h00000;
      div_period <= 16'h0001;
      quot       <= 12'h000;
      iter       <= 4'h0;
      duty_out   <= 12'h000;
    end
    else if (sample_en_in && rise && seen && !timed_out_out)
    begin
      rem        <= {1'b0, high_cnt};
      div_period <= period_cnt;
      quot       <= 12'h000;
      iter       <= 4'hb;
    end
    else if (iter != 4'h0)
    begin
      iter <= iter - 4'h1;
      if (rem_sh >= {1'b0, div_period})
      begin
        rem  <= rem_sh - {1'b0, div_period};
        quot <= {quot[10:0], 1'b1};
      end
      else
      begin
        rem  <= rem_sh;
        quot <= {quot[10:0], 1'b0};
      end
      if (iter == 4'h1)
        duty_out <= {quot[10:0], rem_sh >= {1'b0, div_period}};
    end
    else if (timed_out_out)
      duty_out <= level_in ? backlight_pkg::DUTY_FULL : 12'h000;
  end
endmodule
`default_nettype wire

// >>> current_mapper.sv
// Purpose: maps an 11-bit level to sink current in nA
// Assumes: exponential curve uses a linear fraction for 2^f
// Notes:   result registered, one cycle latency
`timescale 1ns/100ps
`default_nettype none
module current_mapper (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // level in
  input  wire logic        curve_select_in,
  input  wire logic [10:0] level_in,
  // current out
  output logic [24:0]      current_na_out
);
  // log2(1.003040572) scaled by 2^16
  localparam logic [19:0] LOG_STEP   = 20'h0011f;
  localparam logic [24:0] EXP_BASE   = 25'd50000;
  localparam logic [31:0] LIN_OFFSET = 32'd378055;
  localparam logic [31:0] LIN_SLOPE  = 32'd121945;
  localparam logic [31:0] LIN_SCALE  = 32'd10;

  logic [19:0] expo;
  logic [33:0] exp_mant;
  logic [33:0] exp_val;
  logic [31:0] lin_val;

  always_comb
  begin
    expo     = {9'h000, level_in} * LOG_STEP;
    exp_mant = {9'h000, EXP_BASE} * {25'h0, 1'b1, expo[15:8]};
    exp_val  = (exp_mant << expo[19:16]) >> 8;
    lin_val  = (LIN_OFFSET + LIN_SLOPE * {21'h0, level_in})
             / LIN_SCALE;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      current_na_out <= 25'h0000000;
    else if (level_in == 11'h000)
      current_na_out <= 25'h0000000;
    else if (curve_select_in)
      current_na_out <= lin_val[24:0];
    else
      current_na_out <= exp_val[24:0];
  end
endmodule
`default_nettype wire

// >>> pwm_source.sv
// Purpose: pwm brightness source model
// Assumes: 200 MHz clock
// Notes:   a stopped source holds idle_in on the pin
`timescale 1ns/100ps
`default_nettype none
module pwm_source (
  // clock and control
  input  wire logic        clk_in,
  input  wire logic        run_in,
  input  wire logic        idle_in,
  input  wire logic [15:0] high_in,
  // pin
  output logic             pwm_out
);
  int cnt = 0;
  int h;
  // pulses never under 300 cycles, so no sample misses them
  assign h = high_in < 300 ? 300 : (high_in > 9700 ? 9700 : high_in);
  always_ff @(posedge clk_in)
  begin
    // 10000 cycles, 20 kHz
    cnt <= (run_in && cnt < 9999) ? cnt + 1 : 0;
    pwm_out <= run_in ? cnt < h : idle_in;
  end
endmodule
`default_nettype wire

// >>> backlight_assertions.sv
// Purpose: port checks of the brightness path
// Assumes: one register access per cycle
// Notes:   shadows 0x04, 0x05, 0x0a; three cycles allowed to settle
`timescale 1ns/100ps
`default_nettype none
module backlight_checker (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        srst_in,
  // register port
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_rvalid_out,
  // pin and sinks
  input wire logic        pwm_in,
  input wire logic        sink_one_output_out,
  input wire logic        sink_two_output_out,
  input wire logic [24:0] sink_current_na_out,
  input wire logic        backlight_active_out
);
  logic [7:0]  en;
  logic [2:0]  lo;
  logic [10:0] code;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  always_ff @(posedge clk_in)
  begin
    if (srst_in || (reg_wr_in && reg_addr_in == 8'h0a))
      en <= srst_in ? 8'h00 : reg_wdata_in;
    if (srst_in || (reg_wr_in && reg_addr_in == 8'h04))
      lo <= srst_in ? 3'h0 : reg_wdata_in[2:0];
    if (srst_in || (reg_wr_in && reg_addr_in == 8'h05))
      code <= srst_in ? 11'h000 : {reg_wdata_in, lo};
  end
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("answer without read");
  a_unmapped_zero: assert property (reg_rd_in && !(reg_addr_in inside
    {8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0a}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_sink_one_active: assert property (
    sink_one_output_out == backlight_active_out) else $error("sink one");
  a_sink_two_both: assert property (
    sink_two_output_out |-> sink_one_output_out) else $error("sink two");
  a_master_off_dark: assert property (
    !en[0] [*3] |-> !backlight_active_out) else $error("master off lit");
  a_no_sink_dark: assert property (
    (!en[4] && !en[3]) [*3] |-> !backlight_active_out) else $error("no sink");
  a_sink_two_off: assert property (
    !en[3] [*3] |-> !sink_two_output_out) else $error("sink two lit");
  a_zero_code_dark: assert property (
    (code == 11'h000) [*3] |-> !backlight_active_out) else $error("code 0");
endmodule
bind backlight_brightness_control backlight_checker u_backlight_checker (
  .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .pwm_in(pwm_in), .sink_one_output_out(sink_one_output_out),
  .sink_two_output_out(sink_two_output_out),
  .sink_current_na_out(sink_current_na_out),
  .backlight_active_out(backlight_active_out));
`default_nettype wire

// >>> backlight_brightness_control_bench.sv
// Purpose: self-checking bench of the brightness path
// Assumes: short timeouts, one slope tick per ms unit
// Notes:   pwm period 10000 cycles, fast sampling, slow for the held-high timeout check
`timescale 1ns/100ps
`default_nettype none
module backlight_brightness_control_bench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic run = 1'b0;
  logic idle = 1'b0;
  logic [15:0] high = 16'h1388;
  logic pwm, rvalid, s1, s2, act;
  logic [7:0] rdata;
  logic [24:0] cur;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] regs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0a};
  logic [7:0] ens [7] = '{8'h00, 8'h10, 8'h01, 8'h11, 8'h09, 8'h19, 8'h18};
  always #2.5 clk_in = ~clk_in;
  backlight_brightness_control #(.timeout_slow_samples(60),
    .timeout_fast_samples(240), .slope_tick_per_ms(1))
  u_backlight_brightness_control (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en),
    .reg_rd_in(rd_en), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pwm_in(pwm), .sink_one_output_out(s1), .sink_two_output_out(s2),
    .sink_current_na_out(cur), .backlight_active_out(act));
  pwm_source u_pwm_source (.clk_in(clk_in), .run_in(run), .idle_in(idle),
    .high_in(high), .pwm_out(pwm));
  // ********************
  // tasks
  // ********************
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, d);
  endtask
  // model current in nA; exponential allows the coarse power fraction
  function automatic logic near(input logic [24:0] v, input int c,
                                input logic lin);
    real m;
    m = lin ? 37805.5 + 12194.5 * c : 50000.0 * (1.003040572 ** c);
    near = v > m * (lin ? 0.97 : 0.92) && v < m * (lin ? 1.03 : 1.08);
  endfunction
  // ********************
  // sequence
  // ********************
  initial
  begin
    logic [7:0] r;
    logic [1:0] k0;
    logic [1:0] k1;
    logic lb;
    int h, e, p, m;
    void'($urandom(68245));
    cyc(8);
    srst_in <= 1'b0;
    foreach (regs[i])
    begin
      rd_chk(regs[i], 8'h00);
      r = 8'($urandom);
      wr(regs[i], r);
      rd_chk(regs[i], r);
    end
    wr(8'h07, 8'h5a);
    rd_chk(8'h07, 8'h00);
    $display("test registers done");
    foreach (regs[i]) wr(regs[i], 8'h00);
    wr(8'h04, 8'h05);
    wr(8'h0a, 8'h19);
    cyc(8);
    chk(act, 1'b0);
    wr(8'h05, 8'h7d);
    cyc(8);
    chk(act, 1'b1);
    k0 = {near(cur, 1005, 1'b1), near(cur, 1005, 1'b0)};
    wr(8'h02, 8'h10);
    cyc(8);
    k1 = {near(cur, 1005, 1'b1), near(cur, 1005, 1'b0)};
    chk(k0[0] ^ k0[1], 1'b1);
    chk(k1, {k0[0], k0[1]});
    lb = k1[1];
    wr(8'h02, {3'h0, lb, 4'h0});
    foreach (ens[i])
    begin
      wr(8'h0a, ens[i]);
      cyc(6);
      e = ens[i][0] && (ens[i][4] || ens[i][3]);
      chk(act, e[0]);
      chk(s1, e[0]);
      chk(s2, e[0] && ens[i][3]);
    end
    // back to lit, so the zero code alone must darken it
    wr(8'h0a, 8'h19);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    cyc(8);
    chk(act, 1'b0);
    wr(8'h04, 8'h05);
    wr(8'h05, 8'h7d);
    cyc(8);
    $display("test code done");
    wr(8'h03, 8'h08);
    p = cur;
    wr(8'h05, 8'h20);
    cyc(100);
    m = cur;
    cyc(300);
    chk(m < p && m > cur, 1'b1);
    p = cur;
    wr(8'h03, 8'h10);
    wr(8'h05, 8'h7d);
    cyc(300);
    m = cur;
    cyc(300);
    chk(m > p && m < cur, 1'b1);
    $display("test slope done");
    wr(8'h03, 8'h04);
    // whole samples per pulse keep the expected duty exact
    h = 50 * (50 + $urandom_range(100));
    high <= 16'(h);
    run <= 1'b1;
    wr(8'h09, 8'h40);
    cyc(21000);
    e = 1005 * ((h / 50) * 2048 / 200) / 2048;
    chk(near(cur, e, 1'b1), 1'b1);
    wr(8'h02, {3'h0, lb, 4'h8});
    cyc(21000);
    e = 1005 * ((200 - h / 50) * 2048 / 200) / 2048;
    chk(near(cur, e, 1'b1), 1'b1);
    wr(8'h02, {3'h0, lb, 4'h0});
    run <= 1'b0;
    cyc(13000);
    chk(act, 1'b0);
    wr(8'h09, 8'h00);
    cyc(8);
    chk(act, 1'b1);
    wr(8'h03, 8'h00);
    wr(8'h09, 8'h40);
    idle <= 1'b1;
    cyc(13000);
    chk(near(cur, 1005, 1'b1), 1'b1);
    $display("test pwm done");
    finish_test();
  end
endmodule
`default_nettype wire
